/* rtl/brwe_pkg.sv */
/*
  Shared constants for the expansion-bus ready and wait-state extension pair.
  Assumes both ends run on one 25 MHz system clock and count bus time in it.
*/
package brwe_pkg;

  // System clock and bus timing, in picoseconds.
  localparam int CLK_PS = 40000;
  localparam int BUS_T_PS = 125000;
  localparam int STROBE_MARGIN_PS = 35000;
  localparam int SAMPLE_MARGIN_PS = 37000;

  // One bus period rounded up to whole clocks; half a period for ALE and command delay.
  localparam int BUS_T_CYC = (BUS_T_PS + CLK_PS - 1) / CLK_PS;
  localparam int HALF_T_CYC = (BUS_T_CYC + 1) / 2;

  // Programmed wait states and the command strobe low time they produce.
  localparam int PROG_WAITS = 4;
  localparam int CMD_LOW_CYC = PROG_WAITS * BUS_T_CYC + HALF_T_CYC;

  // Clock after the command strobe falls at which ready is first sampled.
  localparam int RDY_SAMPLE_CYC = (PROG_WAITS - 1) * BUS_T_CYC + HALF_T_CYC;

  // Longest time for the card to pull ready low, rounded down.
  localparam int RDY_MAX_PS = (7 * BUS_T_PS) / 2 - STROBE_MARGIN_PS - SAMPLE_MARGIN_PS;
  localparam int RDY_MAX_CYC = RDY_MAX_PS / CLK_PS;

  // Default on-card delay from a valid strobe to dropping the acknowledge.
  localparam int ACK_DLY_CYC = 2;

  // Synchroniser depth and bus widths.
  localparam int SYNC_STAGES = 2;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;

endpackage

/* rtl/brwe_bus_if.sv */
/*
  Expansion-bus signals between the host controller end and the card end.
  Assumes the bench supplies no clock and no other signal; the shared data line is resolved
  here from the enables of both ends, the open-drain ready line from the card's enable and level alone.
*/
`timescale 1ns/1ps
interface brwe_bus_if #(
  parameter int AW = brwe_pkg::ADDR_W,
  parameter int DW = brwe_pkg::DATA_W
);
  logic ale;
  logic [AW-1:0] addr;
  logic mem_sel;
  logic cmd_rd_n;
  logic cmd_wr_n;
  logic [DW-1:0] host_d_o;
  logic host_d_oe_n;
  logic [DW-1:0] dev_d_o;
  logic dev_d_oe_n;
  logic dev_rdy_o;
  logic dev_rdy_oe_n;
  logic [DW-1:0] data_line;
  logic chrdy_line;

  // Data line: whoever enables drives it, the host if both do; idle level is all ones.
  assign data_line = !host_d_oe_n ? host_d_o : (!dev_d_oe_n ? dev_d_o : '1);

  // Ready line is pulled up and only the card may pull it down.
  assign chrdy_line = dev_rdy_oe_n ? 1'b1 : dev_rdy_o;

  modport host (
    output ale, addr, mem_sel, cmd_rd_n, cmd_wr_n, host_d_o, host_d_oe_n,
    input data_line, chrdy_line
  );

  modport dev (
    input ale, addr, mem_sel, cmd_rd_n, cmd_wr_n, data_line,
    output dev_d_o, dev_d_oe_n, dev_rdy_o, dev_rdy_oe_n
  );
endinterface

/* rtl/brwe_host.sv */
/*
  Host expansion-bus controller end: runs 8-bit cycles with ALE, a command delay,
  four programmed wait states and ready-driven extra wait states.
  Assumes a user side that holds a request until it is taken, and a card that
  pulls ready low early enough when it needs more time.
*/
// Behaviour
// RULE1: Memory and I/O cycles share identical timing.
// RULE2: Half-period delay from ALE fall to strobe.
// RULE3: Four programmed waits, strobe low 4.5 periods.
// RULE4: Ready low by third wait adds fifth.
// RULE5: Recheck ready each extra wait until high.
// RULE6: Ready low too late adds no waits.
// RULE7: Card drops acknowledge after valid strobe delay.
// RULE8: Ready line low while acknowledge is dropped.
// RULE9: Bus period is 125 ns, 8 MHz.
// RULE10: Card pulls ready low within 3.5 periods.
// RULE11: Card releases ready when data is done.
`timescale 1ns/1ps
module brwe_host
  import brwe_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
)(
  input wire logic clk,
  input wire logic sys_rst,
  brwe_bus_if.host bus,
  input wire logic req,
  input wire logic req_wr,
  input wire logic req_mem,
  input wire logic [AW-1:0] req_addr,
  input wire logic [DW-1:0] req_wdata,
  output logic busy,
  output logic done,
  output logic [DW-1:0] rdata,
  output logic extended
);

  //////////////////////////////////////////////////////////////////////////////
  // Types and timing.

  typedef enum logic [4:0] {
    BRWE_H_IDLE = 5'h01,
    BRWE_H_ALE = 5'h02,
    BRWE_H_CDLY = 5'h04,
    BRWE_H_CMD = 5'h08,
    BRWE_H_XWAIT = 5'h10
  } brwe_hst_t;

  localparam int CW = 8;
  localparam logic [CW-1:0] HALF_LAST = CW'(HALF_T_CYC - 1); // [RULE2]
  localparam logic [CW-1:0] T_LAST = CW'(BUS_T_CYC - 1); // [RULE9]
  localparam logic [CW-1:0] SAMPLE_AT = CW'(RDY_SAMPLE_CYC - 1);
  localparam logic [CW-1:0] CMD_LAST = CW'(CMD_LOW_CYC - 1);

  brwe_hst_t st_q;
  logic [CW-1:0] cnt_q;
  logic ext_q;
  logic wr_q;
  logic mem_q;
  logic [AW-1:0] addr_q;
  logic [DW-1:0] wdata_q;
  logic done_q;
  logic [DW-1:0] rdata_q;
  logic extended_q;
  logic [SYNC_STAGES-1:0] rdy_sync_q;
  logic [DW-1:0] d_meta_q;
  logic [DW-1:0] d_sync_q;
  logic rdy_s;
  logic take;
  logic finish;
  logic strobe_on;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers for the ready and data lines.

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rdy_sync_q <= '1;
    end
    else
    begin
      rdy_sync_q <= {rdy_sync_q[SYNC_STAGES-2:0], bus.chrdy_line};
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      d_meta_q <= '0;
      d_sync_q <= '0;
    end
    else
    begin
      d_meta_q <= bus.data_line;
      d_sync_q <= d_meta_q;
    end
  end

  assign rdy_s = rdy_sync_q[SYNC_STAGES-1];

  //////////////////////////////////////////////////////////////////////////////
  // Request capture.

  assign take = req && (st_q == BRWE_H_IDLE);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_q <= 1'b0;
      mem_q <= 1'b0;
      addr_q <= '0;
      wdata_q <= '0;
    end
    else if (take)
    begin
      wr_q <= req_wr;
      mem_q <= req_mem;
      addr_q <= req_addr;
      wdata_q <= req_wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Cycle sequencer.

  // Memory and I/O requests walk the very same states and counts.
  always_comb
  begin
    finish = 1'b0;
    case (st_q)
      BRWE_H_CMD: finish = (cnt_q == CMD_LAST) && !ext_q; // [RULE1] [RULE3] [RULE6]
      BRWE_H_XWAIT: finish = (cnt_q == T_LAST) && rdy_s; // [RULE5]
      default: finish = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q <= BRWE_H_IDLE;
      cnt_q <= '0;
    end
    else
    begin
      case (st_q)
        BRWE_H_IDLE:
        begin
          cnt_q <= '0;
          if (take)
          begin
            st_q <= BRWE_H_ALE;
          end
        end
        BRWE_H_ALE:
        begin
          cnt_q <= (cnt_q == HALF_LAST) ? '0 : cnt_q + 1'b1;
          if (cnt_q == HALF_LAST)
          begin
            st_q <= BRWE_H_CDLY;
          end
        end
        BRWE_H_CDLY:
        begin
          cnt_q <= (cnt_q == HALF_LAST) ? '0 : cnt_q + 1'b1;
          if (cnt_q == HALF_LAST) // [RULE2]
          begin
            st_q <= BRWE_H_CMD;
          end
        end
        BRWE_H_CMD:
        begin
          cnt_q <= (cnt_q == CMD_LAST) ? '0 : cnt_q + 1'b1;
          if (cnt_q == CMD_LAST) // [RULE3]
          begin
            st_q <= ext_q ? BRWE_H_XWAIT : BRWE_H_IDLE; // [RULE4]
          end
        end
        BRWE_H_XWAIT:
        begin
          cnt_q <= (cnt_q == T_LAST) ? '0 : cnt_q + 1'b1;
          if (finish)
          begin
            st_q <= BRWE_H_IDLE;
          end
        end
        default:
        begin
          st_q <= BRWE_H_IDLE;
          cnt_q <= '0;
        end
      endcase
    end
  end

  // Ready is looked at once, at the end of the third programmed wait state.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ext_q <= 1'b0;
    end
    else if (take)
    begin
      ext_q <= 1'b0;
    end
    else if ((st_q == BRWE_H_CMD) && (cnt_q == SAMPLE_AT))
    begin
      ext_q <= !rdy_s; // [RULE4] [RULE6]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Results to the user side.

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      done_q <= 1'b0;
      rdata_q <= '0;
      extended_q <= 1'b0;
    end
    else
    begin
      done_q <= finish;
      if (finish)
      begin
        extended_q <= (st_q == BRWE_H_XWAIT);
        if (!wr_q)
        begin
          rdata_q <= d_sync_q;
        end
      end
    end
  end

  assign busy = (st_q != BRWE_H_IDLE);
  assign done = done_q;
  assign rdata = rdata_q;
  assign extended = extended_q;

  //////////////////////////////////////////////////////////////////////////////
  // Bus pins.

  assign strobe_on = (st_q == BRWE_H_CMD) || (st_q == BRWE_H_XWAIT);
  assign bus.ale = (st_q == BRWE_H_ALE);
  assign bus.addr = addr_q;
  assign bus.mem_sel = mem_q;
  assign bus.cmd_rd_n = !(strobe_on && !wr_q);
  assign bus.cmd_wr_n = !(strobe_on && wr_q);
  assign bus.host_d_o = wdata_q;
  // Write data waits for the command delay so a card still driving read data can let go.
  assign bus.host_d_oe_n = !(wr_q && (st_q != BRWE_H_IDLE) && (st_q != BRWE_H_ALE)); // [RULE1]

endmodule // brwe_host

/* rtl/brwe_card.sv */
/*
  Card end: turns host command strobes into remote read and write strobes for
  the on-board processor and holds the ready line low until the transfer is done.
  Assumes the processor answers each strobe with one loc_done pulse.
*/
`timescale 1ns/1ps
module brwe_card
  import brwe_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W,
  parameter int ACK_DLY = ACK_DLY_CYC
)(
  input wire logic clk,
  input wire logic sys_rst,
  brwe_bus_if.dev bus,
  output logic remote_read_strobe,
  output logic remote_write_strobe,
  output logic rem_mem,
  output logic [AW-1:0] rem_addr,
  output logic [DW-1:0] rem_wdata,
  input wire logic loc_done,
  input wire logic [DW-1:0] loc_rdata,
  output logic transfer_acknowledge
);

  //////////////////////////////////////////////////////////////////////////////
  // Types and synchronisers.

  typedef enum logic [3:0] {
    BRWE_C_IDLE = 4'h1,
    BRWE_C_DLY = 4'h2,
    BRWE_C_HOLD = 4'h4,
    BRWE_C_DONE = 4'h8
  } brwe_crd_t;

  localparam int CW = 8;
  localparam logic [CW-1:0] DLY_LAST = CW'(ACK_DLY - 1);

  // Strobe sync, acknowledge delay and the drive flop must fit the ready budget.
  localparam bit BUDGET_OK = (SYNC_STAGES + ACK_DLY + 1) <= RDY_MAX_CYC; // [RULE10]

  logic [4+AW+DW-1:0] meta_q;
  logic [4+AW+DW-1:0] sync_q;
  logic ale_s;
  logic rd_s;
  logic wr_s;
  logic mem_s;
  logic [AW-1:0] addr_s;
  logic [DW-1:0] data_s;
  logic ale_d_q;
  logic [AW-1:0] addr_q;
  brwe_crd_t st_q;
  logic [CW-1:0] cnt_q;
  logic rd_cyc_q;
  logic done_seen_q;
  logic ack_q;
  logic [DW-1:0] rdata_q;
  logic rstb_q;
  logic wstb_q;
  logic mem_q;
  logic [DW-1:0] wdata_q;
  logic cmd_act;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_q <= {4'h0, {AW{1'b0}}, {DW{1'b0}}};
      sync_q <= {4'h0, {AW{1'b0}}, {DW{1'b0}}};
    end
    else
    begin
      meta_q <= {bus.ale, !bus.cmd_rd_n, !bus.cmd_wr_n, bus.mem_sel, bus.addr, bus.data_line};
      sync_q <= meta_q;
    end
  end

  assign {ale_s, rd_s, wr_s, mem_s, addr_s, data_s} = sync_q;
  assign cmd_act = rd_s || wr_s;

  // Address is held from the falling edge of ALE.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ale_d_q <= 1'b0;
      addr_q <= '0;
    end
    else
    begin
      ale_d_q <= ale_s;
      if (ale_d_q && !ale_s)
      begin
        addr_q <= addr_s;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transfer sequencer.

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q <= BRWE_C_IDLE;
      cnt_q <= '0;
      ack_q <= 1'b1;
      rd_cyc_q <= 1'b0;
      done_seen_q <= 1'b0;
      rdata_q <= '0;
    end
    else
    begin
      case (st_q)
        BRWE_C_IDLE:
        begin
          cnt_q <= '0;
          done_seen_q <= 1'b0;
          if (cmd_act && BUDGET_OK)
          begin
            rd_cyc_q <= rd_s;
            st_q <= BRWE_C_DLY;
          end
        end
        BRWE_C_DLY:
        begin
          cnt_q <= cnt_q + 1'b1;
          if (loc_done)
          begin
            done_seen_q <= 1'b1;
            rdata_q <= loc_rdata;
          end
          if (cnt_q == DLY_LAST)
          begin
            ack_q <= 1'b0; // [RULE7]
            st_q <= BRWE_C_HOLD;
          end
        end
        BRWE_C_HOLD:
        begin
          if (loc_done || done_seen_q)
          begin
            if (loc_done)
            begin
              rdata_q <= loc_rdata;
            end
            ack_q <= 1'b1; // [RULE11]
            st_q <= BRWE_C_DONE;
          end
        end
        BRWE_C_DONE:
        begin
          if (!cmd_act)
          begin
            st_q <= BRWE_C_IDLE;
          end
        end
        default:
        begin
          st_q <= BRWE_C_IDLE;
          ack_q <= 1'b1;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Remote strobes toward the processor.

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rstb_q <= 1'b0;
      wstb_q <= 1'b0;
      mem_q <= 1'b0;
      wdata_q <= '0;
    end
    else
    begin
      rstb_q <= (st_q == BRWE_C_IDLE) && rd_s && BUDGET_OK;
      wstb_q <= (st_q == BRWE_C_IDLE) && wr_s && !rd_s && BUDGET_OK;
      if ((st_q == BRWE_C_IDLE) && cmd_act)
      begin
        mem_q <= mem_s;
        wdata_q <= data_s;
      end
    end
  end

  assign remote_read_strobe = rstb_q;
  assign remote_write_strobe = wstb_q;
  assign rem_mem = mem_q;
  assign rem_addr = addr_q;
  assign rem_wdata = wdata_q;
  assign transfer_acknowledge = ack_q;

  //////////////////////////////////////////////////////////////////////////////
  // Bus pins.

  assign bus.dev_rdy_o = 1'b0;
  assign bus.dev_rdy_oe_n = ack_q; // [RULE8] [RULE4]
  assign bus.dev_d_o = rdata_q;
  assign bus.dev_d_oe_n = !(rd_cyc_q && (st_q == BRWE_C_DONE) && rd_s); // [RULE11]

endmodule // brwe_card

/* sim/brwe_bus_asserts.sv */
/*
  Checker for the bus between the host end and the card end.
  Assumes it is instantiated beside the interface and sees its signals.
*/
`timescale 1ns/1ps
module brwe_bus_asserts
  import brwe_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ale,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic mem_sel,
  input wire logic cmd_rd_n,
  input wire logic cmd_wr_n,
  input wire logic host_d_oe_n,
  input wire logic dev_d_oe_n,
  input wire logic chrdy_line
);
  logic strb;
  logic [7:0] cnt_q;
  logic rdy_lo_q;
  assign strb = !(cmd_rd_n && cmd_wr_n);
  ////////////////////////////////////////////////////////////////
  // Counts the clocks for which a command strobe has been low.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      cnt_q <= 8'h00;
    else
      cnt_q <= strb ? cnt_q + 8'h01 : 8'h00;
  end
  // Notes a ready drop close enough to the sample point to count.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      rdy_lo_q <= 1'b0;
    else if (!strb)
      rdy_lo_q <= 1'b0;
    else if (cnt_q >= 8'h08 && !chrdy_line)
      rdy_lo_q <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_ale_two_clocks: assert property ($rose(ale) |-> ale [*2] ##1 !ale)
    else $error("address latch pulse has wrong width");
  a_cmd_delay_half: assert property ($fell(ale) |-> !strb ##1 !strb ##1 strb)
    else $error("command delay after latch is wrong");
  a_strobe_len_ok: assert property ($fell(strb) |-> cnt_q >= 8'h12 && cnt_q[1:0] == 2'b10)
    else $error("command strobe length is wrong");
  a_early_adds_wait: assert property ((strb && cnt_q == 8'h06 && !chrdy_line) ##1 (!chrdy_line) [*7]
    |-> ##6 (strb && cnt_q == 8'h13))
    else $error("early ready drop did not add a wait");
  a_late_no_ext: assert property (strb && cnt_q == 8'h12 |-> rdy_lo_q)
    else $error("cycle extended without a timely ready drop");
  a_ext_release_end: assert property (strb && cnt_q >= 8'h13 && $rose(chrdy_line) |-> ##[1:8] !strb)
    else $error("extended cycle did not end after ready rose");
  a_rdy_deadline_met: assert property ($rose(strb) |-> ##[1:9] !chrdy_line)
    else $error("card pulled ready low too late");
  a_rdy_idle_high: assert property (!strb |-> chrdy_line)
    else $error("ready low outside a command");
  a_data_no_clash: assert property (!dev_d_oe_n |-> host_d_oe_n && cmd_wr_n)
    else $error("card drives data during a write");
  a_addr_held_cmd: assert property (strb |-> $stable(addr) && $stable(mem_sel))
    else $error("address moved during a command");
  c_ext_cycle: cover property (strb && cnt_q == 8'h16);
  c_plain_end: cover property ($fell(strb) && cnt_q == 8'h12);
  c_write_cmd: cover property ($fell(cmd_wr_n));
  c_card_drives: cover property ($fell(dev_d_oe_n));
endmodule // brwe_bus_asserts

/* sim/tb_top.sv */
/*
  Testbench joining the host end and the card end through the bus interface.
  Assumes the design files and package are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  import brwe_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req = 1'b0;
  logic req_wr = 1'b0;
  logic req_mem = 1'b0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DATA_W-1:0] req_wdata = '0;
  logic busy, done, extended, rd_stb, wr_stb, rem_mem, ack;
  logic [DATA_W-1:0] rdata, rem_wdata;
  logic [ADDR_W-1:0] rem_addr;
  logic loc_done = 1'b0;
  logic [DATA_W-1:0] loc_rdata = '0;
  int error_cnt = 0;
  int check_count = 0;
  int ldly = 3;
  int dly_tab[4] = '{3, 5, 20, 40};
  logic [DATA_W+1:0] host_q[$];
  logic [DATA_W+1:0] exp_h;
  logic [ADDR_W+DATA_W+1:0] card_q[$];
  logic [ADDR_W+DATA_W+1:0] exp_c;
  always #20 clk = ~clk;
  brwe_bus_if brwe_bus_if_i ();
  brwe_host brwe_host_i (.clk(clk), .sys_rst(sys_rst), .bus(brwe_bus_if_i.host), .req(req), .req_wr(req_wr),
    .req_mem(req_mem), .req_addr(req_addr), .req_wdata(req_wdata), .busy(busy), .done(done), .rdata(rdata),
    .extended(extended));
  brwe_card brwe_card_i (.clk(clk), .sys_rst(sys_rst), .bus(brwe_bus_if_i.dev), .remote_read_strobe(rd_stb),
    .remote_write_strobe(wr_stb), .rem_mem(rem_mem), .rem_addr(rem_addr), .rem_wdata(rem_wdata),
    .loc_done(loc_done), .loc_rdata(loc_rdata), .transfer_acknowledge(ack));
  brwe_bus_asserts brwe_bus_asserts_i (.clk(clk), .sys_rst(sys_rst), .ale(brwe_bus_if_i.ale),
    .addr(brwe_bus_if_i.addr), .mem_sel(brwe_bus_if_i.mem_sel), .cmd_rd_n(brwe_bus_if_i.cmd_rd_n),
    .cmd_wr_n(brwe_bus_if_i.cmd_wr_n), .host_d_oe_n(brwe_bus_if_i.host_d_oe_n),
    .dev_d_oe_n(brwe_bus_if_i.dev_d_oe_n), .chrdy_line(brwe_bus_if_i.chrdy_line));
  ////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1)
    begin
      $display("CHECK FAILED %0t %s", $time, msg);
      error_cnt++;
    end
  endtask
  // Runs one host cycle; the card side answers after dly clocks.
  task automatic run_cycle(input logic wr, input logic mem, input int dly);
    int n;
    logic [DATA_W-1:0] d;
    logic [ADDR_W-1:0] a;
    d = DATA_W'($urandom);
    a = ADDR_W'($urandom);
    ldly = dly;
    loc_rdata = d;
    host_q.push_back({wr, dly > 12, d});
    card_q.push_back({wr, mem, a, d});
    req_wr = wr;
    req_mem = mem;
    req_addr = a;
    req_wdata = d;
    req = 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      #1 n++;
    end
    while (busy !== 1'b1 && n < 50);
    req = 1'b0;
    while (done !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      #1 n++;
    end
    check(n < 300, "cycle did not complete");
    if (n >= 300)
      print_verdict();
  endtask
  ////////////////////////////////////////////////////////////////
  // Plays the on-card processor and checks what the card hands it.
  initial
  begin
    forever
    begin
      @(posedge clk);
      if (rd_stb === 1'b1 || wr_stb === 1'b1)
      begin
        exp_c = card_q.pop_front();
        check(wr_stb === exp_c[ADDR_W+DATA_W+1] && rem_mem === exp_c[ADDR_W+DATA_W], "strobe kind");
        check(rem_addr === exp_c[ADDR_W+DATA_W-1:DATA_W], "remote address");
        repeat (ldly) @(posedge clk);
        #1 loc_done = 1'b1;
        check(ack === 1'b0, "acknowledge not dropped");
        if (exp_c[ADDR_W+DATA_W+1])
          check(rem_wdata === exp_c[DATA_W-1:0], "write data");
        @(posedge clk);
        #1 loc_done = 1'b0;
        check(ack === 1'b1, "acknowledge not restored");
      end
    end
  end
  // Compares each finished cycle with the oldest expectation.
  always @(posedge clk)
  begin
    if (done === 1'b1)
    begin
      exp_h = host_q.pop_front();
      check(extended === exp_h[DATA_W], "extension");
      check(busy === 1'b0, "busy after done");
      if (!exp_h[DATA_W+1])
        check(rdata === exp_h[DATA_W-1:0], "read data");
    end
  end
  initial
  begin
    void'($urandom(32'h7e7948eb));
    repeat (6) @(posedge clk);
    #1 sys_rst = 1'b0;
    for (int i = 0; i < 16; i++)
      run_cycle(i[0], i[1], dly_tab[i[3:2]]);
    for (int i = 0; i < 12; i++)
      run_cycle($urandom % 2, $urandom % 2, ($urandom % 2) ? 3 + $urandom % 3 : 16 + $urandom % 20);
    repeat (3) @(posedge clk);
    check(host_q.size() == 0 && card_q.size() == 0, "cycles left over");
    print_verdict();
  end
endmodule // tb_top
